// ---- design/clock_control_consts.vh ----
`ifndef CLOCK_CONTROL_CONSTS_VH
`define CLOCK_CONTROL_CONSTS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_VIDEO_SYNTH 12'h040
`define OFS_CORE_SYNTH 12'h044
`define OFS_BUS_SYNTH 12'h048
`define OFS_CLOCK_STATUS 12'h038

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define POST_DIV_LSB 0
`define POST_DIV_MSB 1
`define IN_DIV_LSB 2
`define IN_DIV_MSB 7
`define FB_MUL_LSB 8
`define FB_MUL_MSB 15
`define TEST_BIT 16
`define MUX_LSB 0
`define MUX_MSB 1

// ---------------------------------------------------------------
// reset values and fixed values
// ---------------------------------------------------------------
`define SYNTH_RESET 17'h00000
`define MUX_RESET 2'h0
`define FORCED_IN_DIV 6'h18
`define STRAP_SETTLE 2'h2

// ---------------------------------------------------------------
// source select and divide codes (divide is log2 of ratio)
// ---------------------------------------------------------------
`define SRC_BUS_IN 1'b0
`define SRC_SYNTH 1'b1
`define DIV_BY_1 2'h0
`define DIV_BY_2 2'h1
`define DIV_BY_4 2'h2

`endif

// ---- design/pll_bus_clock_control.v ----
`timescale 1ns/1ps
`include "clock_control_consts.vh"

// Notes on behaviour
// - three 32-bit synth registers at 0x40, 0x44, 0x48: video, core, bus.
// - video/core fields: post-divider exponent 1:0, input divider 7:2, multiplier 15:8.
// - bit 16 of video/core: test, clock taken from oscillator; resets zero.
// - fout = ref * (mult + 2) / (indiv + 2) / 2^postdiv.
// - for one part identifier the core input divider is forced to 0x18.
// - bus synth register bits 1:0 hold the test mux state.
// - fast strap zero: both internal bus clocks are the incoming bus clock.
// - fast one, bypass zero, mux 00: quarter and half of synth output.
// - fast one, bypass zero, mux 1x: logic clock is bus clock; double rate from synth or bus.
// - fast one with bypass one or mux 01: quarter and half of incoming bus clock.
// - fast strap makes config status report 66 MHz capability.
// - logic clock runs bus logic; double-rate clock only launches outputs.
module pll_bus_clock_control #(
    parameter [7:0] PART_IDENTIFIER = 8'h00, // arbitrary value
    parameter [7:0] FORCED_DIV_PART = 8'h5A // arbitrary value
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire fast_bus_strap,
    input wire bypass_strap,
    output reg [1:0] video_post_div,
    output reg [5:0] video_in_div,
    output reg [7:0] video_fb_mul,
    output reg video_osc_test,
    output reg [1:0] core_post_div,
    output reg [5:0] core_in_div,
    output reg [7:0] core_fb_mul,
    output reg core_osc_test,
    output reg bus_logic_clock_src,
    output reg [1:0] bus_logic_clock_div,
    output reg double_rate_out_clock_src,
    output reg [1:0] double_rate_out_clock_div,
    output reg single_rate_only,
    output reg test_only_mode,
    output reg fast_bus_capable,
    output reg straps_valid
);

    // -----------------------------------------------------------
    // register storage
    // -----------------------------------------------------------
    reg [16:0] video_synth_r;
    reg [16:0] core_synth_r;
    reg [1:0] bus_mux_r;
    reg fast_meta_r;
    reg fast_sync_r;
    reg bypass_meta_r;
    reg bypass_sync_r;
    reg [1:0] settle_r;
    reg fast_held_r;
    reg bypass_held_r;
    reg held_r;

    wire setup_phase;
    wire wr_commit;
    wire [5:0] core_in_div_eff;
    reg [31:0] rd_nxt;
    reg rd_err_nxt;
    reg bl_src_nxt;
    reg [1:0] bl_div_nxt;
    reg dr_src_nxt;
    reg [1:0] dr_div_nxt;
    reg single_nxt;
    reg test_nxt;

    assign setup_phase = psel & ~penable;
    assign wr_commit = psel & penable & pready & pwrite & ~pslverr;

    // -----------------------------------------------------------
    // apb read decode, answered one cycle after setup
    // -----------------------------------------------------------
    always @* begin
        rd_nxt = 32'h00000000;
        rd_err_nxt = 1'b0;
        case (paddr)
            `OFS_VIDEO_SYNTH: rd_nxt = {15'h0000, video_synth_r};
            `OFS_CORE_SYNTH: rd_nxt = {15'h0000, core_synth_r};
            `OFS_BUS_SYNTH: rd_nxt = {30'h00000000, bus_mux_r};
            `OFS_CLOCK_STATUS: rd_nxt = {24'h000000, held_r, test_only_mode,
                single_rate_only, fast_bus_capable, bypass_held_r, fast_held_r,
                bus_mux_r};
            default: rd_err_nxt = 1'b1;
        endcase
    end

    // apb answer flops: pready rises in the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase & (rd_err_nxt | (pwrite && paddr == `OFS_CLOCK_STATUS));
            if (setup_phase && !pwrite) begin
                prdata <= rd_nxt;
            end
        end
    end

    // -----------------------------------------------------------
    // register writes
    // -----------------------------------------------------------
    // synth registers, test bit resets to zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            video_synth_r <= `SYNTH_RESET;
            core_synth_r <= `SYNTH_RESET;
            bus_mux_r <= `MUX_RESET;
        end else if (wr_commit) begin
            if (paddr == `OFS_VIDEO_SYNTH) begin
                video_synth_r <= pwdata[16:0];
            end
            if (paddr == `OFS_CORE_SYNTH) begin
                core_synth_r <= pwdata[16:0];
            end
            if (paddr == `OFS_BUS_SYNTH) begin
                bus_mux_r <= pwdata[`MUX_MSB:`MUX_LSB];
            end
        end
    end

    // -----------------------------------------------------------
    // strap synchronise and hold
    // -----------------------------------------------------------
    // two-flop synchronisers for the strap pins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_meta_r <= 1'b0;
            fast_sync_r <= 1'b0;
            bypass_meta_r <= 1'b0;
            bypass_sync_r <= 1'b0;
        end else begin
            fast_meta_r <= fast_bus_strap;
            fast_sync_r <= fast_meta_r;
            bypass_meta_r <= bypass_strap;
            bypass_sync_r <= bypass_meta_r;
        end
    end

    // capture once after release, then freeze
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_r <= 2'h0;
            fast_held_r <= 1'b0;
            bypass_held_r <= 1'b0;
            held_r <= 1'b0;
        end else if (!held_r) begin
            if (settle_r == `STRAP_SETTLE) begin
                fast_held_r <= fast_sync_r;
                bypass_held_r <= bypass_sync_r;
                held_r <= 1'b1;
            end else begin
                settle_r <= settle_r + 2'h1;
            end
        end
    end

    // -----------------------------------------------------------
    // clock source selection
    // -----------------------------------------------------------
    // logic clock feeds bus logic, double-rate only output launch
    always @* begin
        bl_src_nxt = `SRC_BUS_IN;
        bl_div_nxt = `DIV_BY_1;
        dr_src_nxt = `SRC_BUS_IN;
        dr_div_nxt = `DIV_BY_1;
        single_nxt = 1'b0;
        test_nxt = 1'b0;
        if (!fast_held_r) begin
            bl_src_nxt = `SRC_BUS_IN;
        // bypass strap: test-only quarter and half
        end else if (bypass_held_r) begin
            bl_div_nxt = `DIV_BY_4;
            dr_div_nxt = `DIV_BY_2;
            test_nxt = 1'b1;
        end else begin
            case (bus_mux_r)
                2'h0: begin
                    bl_src_nxt = `SRC_SYNTH;
                    bl_div_nxt = `DIV_BY_4;
                    dr_src_nxt = `SRC_SYNTH;
                    dr_div_nxt = `DIV_BY_2;
                end
                2'h1: begin
                    bl_div_nxt = `DIV_BY_4;
                    dr_div_nxt = `DIV_BY_2;
                    test_nxt = 1'b1;
                end
                2'h2: begin
                    dr_src_nxt = `SRC_SYNTH;
                    dr_div_nxt = `DIV_BY_2;
                    single_nxt = 1'b1;
                end
                default: begin
                    dr_div_nxt = `DIV_BY_2;
                    single_nxt = 1'b1;
                end
            endcase
        end
    end

    // forced core input divider for the one part
    assign core_in_div_eff = (PART_IDENTIFIER == FORCED_DIV_PART) ? `FORCED_IN_DIV :
        core_synth_r[`IN_DIV_MSB:`IN_DIV_LSB];

    // -----------------------------------------------------------
    // registered outputs
    // -----------------------------------------------------------
    // field split, synthesizer uses n+2, m+2, 2^k
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            video_post_div <= 2'h0;
            video_in_div <= 6'h00;
            video_fb_mul <= 8'h00;
            video_osc_test <= 1'b0;
            core_post_div <= 2'h0;
            core_in_div <= 6'h00;
            core_fb_mul <= 8'h00;
            core_osc_test <= 1'b0;
            bus_logic_clock_src <= `SRC_BUS_IN;
            bus_logic_clock_div <= `DIV_BY_1;
            double_rate_out_clock_src <= `SRC_BUS_IN;
            double_rate_out_clock_div <= `DIV_BY_1;
            single_rate_only <= 1'b0;
            test_only_mode <= 1'b0;
            fast_bus_capable <= 1'b0;
            straps_valid <= 1'b0;
        end else begin
            video_post_div <= video_synth_r[`POST_DIV_MSB:`POST_DIV_LSB];
            video_in_div <= video_synth_r[`IN_DIV_MSB:`IN_DIV_LSB];
            video_fb_mul <= video_synth_r[`FB_MUL_MSB:`FB_MUL_LSB];
            video_osc_test <= video_synth_r[`TEST_BIT];
            core_post_div <= core_synth_r[`POST_DIV_MSB:`POST_DIV_LSB];
            core_in_div <= core_in_div_eff;
            core_fb_mul <= core_synth_r[`FB_MUL_MSB:`FB_MUL_LSB];
            core_osc_test <= core_synth_r[`TEST_BIT];
            bus_logic_clock_src <= bl_src_nxt;
            bus_logic_clock_div <= bl_div_nxt;
            double_rate_out_clock_src <= dr_src_nxt;
            double_rate_out_clock_div <= dr_div_nxt;
            single_rate_only <= single_nxt;
            // flags a combination software should avoid
            test_only_mode <= test_nxt;
            // capability report follows the fast strap as held after reset release
            fast_bus_capable <= fast_held_r;
            straps_valid <= held_r;
        end
    end

endmodule // pll_bus_clock_control

// ---- bench/pll_bus_clock_control_properties.sv ----
`timescale 1ns/1ps
`include "clock_control_consts.vh"
// ----
// bus and clock-select checks
// ----
module pll_bus_clock_control_properties #(
    parameter [7:0] PART_IDENTIFIER = 8'h00,
    parameter [7:0] FORCED_DIV_PART = 8'h5A
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire [7:0] video_fb_mul,
    input wire [5:0] core_in_div,
    input wire bus_logic_clock_src,
    input wire [1:0] bus_logic_clock_div,
    input wire double_rate_out_clock_src,
    input wire [1:0] double_rate_out_clock_div,
    input wire single_rate_only,
    input wire test_only_mode,
    input wire fast_bus_capable,
    input wire straps_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // decoded request helpers
    wire setup = psel && !penable;
    wire [7:0] wmul = pwdata[15:8];
    wire mapped = paddr == `OFS_VIDEO_SYNTH || paddr == `OFS_CORE_SYNTH
        || paddr == `OFS_BUS_SYNTH || paddr == `OFS_CLOCK_STATUS;
    wire [5:0] sel = {bus_logic_clock_src, bus_logic_clock_div,
        double_rate_out_clock_src, double_rate_out_clock_div};
    a_pready_one_cycle: assert property (setup |=> pready ##1 !pready)
        else $error("pready not a single access cycle");
    a_err_unmapped: assert property (setup && !mapped |=> pready && pslverr)
        else $error("unmapped access not refused");
    a_video_mul_write: assert property (psel && penable && pready && pwrite
        && paddr == `OFS_VIDEO_SYNTH |-> ##2 video_fb_mul == $past(wmul, 2))
        else $error("video multiplier not updated");
    a_core_div_forced: assert property (straps_valid && PART_IDENTIFIER == FORCED_DIV_PART
        |-> core_in_div == `FORCED_IN_DIV)
        else $error("core input divider not forced");
    a_slow_bus_bypass: assert property (straps_valid && !fast_bus_capable |-> sel == 6'h00)
        else $error("slow bus not on incoming clock");
    a_single_rate_sel: assert property (single_rate_only |-> !bus_logic_clock_src
        && bus_logic_clock_div == `DIV_BY_1 && double_rate_out_clock_div == `DIV_BY_2)
        else $error("single rate selection wrong");
    a_test_mode_sel: assert property (test_only_mode |-> sel == {`SRC_BUS_IN, `DIV_BY_4,
        `SRC_BUS_IN, `DIV_BY_2})
        else $error("test mode selection wrong");
    a_straps_held: assert property ($rose(straps_valid) |=> straps_valid[*8])
        else $error("strap capture dropped");
    c_synth_mode: cover property (bus_logic_clock_src && double_rate_out_clock_src);
    c_single_mode: cover property (single_rate_only);
    c_refused: cover property (pready && pslverr);
endmodule // pll_bus_clock_control_properties

bind pll_bus_clock_control pll_bus_clock_control_properties #(
    .PART_IDENTIFIER(PART_IDENTIFIER), .FORCED_DIV_PART(FORCED_DIV_PART)
) props_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .video_fb_mul(video_fb_mul), .core_in_div(core_in_div),
    .bus_logic_clock_src(bus_logic_clock_src), .bus_logic_clock_div(bus_logic_clock_div),
    .double_rate_out_clock_src(double_rate_out_clock_src),
    .double_rate_out_clock_div(double_rate_out_clock_div),
    .single_rate_only(single_rate_only), .test_only_mode(test_only_mode),
    .fast_bus_capable(fast_bus_capable), .straps_valid(straps_valid));

// ---- bench/board_strap_model.sv ----
`timescale 1ns/1ps
// ----
// board strap fitting
// ----
module board_strap_model (
    input wire [1:0] board_mode,
    output wire fast_bus_strap,
    output wire bypass_strap
);
    // supported fittings
    // resistors always drive; test fittings only when the bench asks
    assign fast_bus_strap = board_mode[1];
    assign bypass_strap = board_mode[0];
endmodule // board_strap_model

// ---- bench/pll_bus_clock_control_test.sv ----
`timescale 1ns/1ps
`include "clock_control_consts.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, (a), (b)); end end
module pll_bus_clock_control_test;
    reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, d, rd;
    reg [1:0] board_mode = 2'h2;
    reg [7:0] s;
    wire [31:0] prdata;
    wire pready, pslverr, fast_bus_strap, bypass_strap, video_osc_test, core_osc_test;
    wire bus_logic_clock_src, double_rate_out_clock_src, single_rate_only, test_only_mode;
    wire fast_bus_capable, straps_valid;
    wire [1:0] video_post_div, core_post_div, bus_logic_clock_div, double_rate_out_clock_div;
    wire [5:0] video_in_div, core_in_div;
    wire [7:0] video_fb_mul, core_fb_mul;
    wire [7:0] sel_obs = {bus_logic_clock_src, bus_logic_clock_div, double_rate_out_clock_src,
        double_rate_out_clock_div, single_rate_only, test_only_mode};
    integer n_mismatch = 0, total_checks = 0, k, m, x;
    // 50 MHz clock
    always #10 pclk = ~pclk;
    pll_bus_clock_control #(.PART_IDENTIFIER(8'h5A), .FORCED_DIV_PART(8'h5A))
    pll_bus_clock_control_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fast_bus_strap(fast_bus_strap),
        .bypass_strap(bypass_strap), .video_post_div(video_post_div),
        .video_in_div(video_in_div), .video_fb_mul(video_fb_mul),
        .video_osc_test(video_osc_test), .core_post_div(core_post_div),
        .core_in_div(core_in_div), .core_fb_mul(core_fb_mul), .core_osc_test(core_osc_test),
        .bus_logic_clock_src(bus_logic_clock_src), .bus_logic_clock_div(bus_logic_clock_div),
        .double_rate_out_clock_src(double_rate_out_clock_src),
        .double_rate_out_clock_div(double_rate_out_clock_div),
        .single_rate_only(single_rate_only), .test_only_mode(test_only_mode),
        .fast_bus_capable(fast_bus_capable), .straps_valid(straps_valid));
    board_strap_model board_strap_model_inst (.board_mode(board_mode),
        .fast_bus_strap(fast_bus_strap), .bypass_strap(bypass_strap));
    // ----
    // helpers
    // ----
    task conclude;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_mismatch);
            if (n_mismatch == 0 && total_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // one apb transfer, waits for pready under a bound
    task apb(input w, input [11:0] a, input [31:0] dt);
        integer i;
        begin
            @(posedge pclk);
            psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= dt;
            @(posedge pclk);
            penable <= 1'b1;
            i = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && i < 16) begin @(posedge pclk); i = i + 1; end
            if (i == 16) begin n_mismatch++; conclude; end
            rd = prdata; e = pslverr; psel <= 1'b0; penable <= 1'b0;
        end
    endtask
    task rst(input [1:0] bm);
        begin
            presetn <= 1'b0; board_mode <= bm;
            repeat (16) @(posedge pclk);
            presetn <= 1'b1;
            repeat (6) @(posedge pclk);
        end
    endtask
    // expected {logic src,div, double src,div, single, test}
    function [7:0] exp_sel(input f, input b, input [1:0] mx);
        if (!f) exp_sel = 8'h00;
        else if (b || mx == 2'h1) exp_sel = {`SRC_BUS_IN, `DIV_BY_4, `SRC_BUS_IN, `DIV_BY_2, 2'h1};
        else if (mx == 2'h0) exp_sel = {`SRC_SYNTH, `DIV_BY_4, `SRC_SYNTH, `DIV_BY_2, 2'h0};
        else exp_sel = {`SRC_BUS_IN, `DIV_BY_1, mx == 2'h2, `DIV_BY_2, 2'h2};
    endfunction
    // ----
    // main sequence
    // ----
    initial begin
        x = $urandom(32'h454d);
        rst(2'h2);
        for (k = 0; k < 3; k++) begin
            apb(1'b0, `OFS_VIDEO_SYNTH + 12'(k * 4), 32'h0);
            `CHK({e, rd}, 33'h0)
        end
        $display("test reset_values done");
        for (k = 0; k < 10; k++) begin
            d = (k < 2) ? 32'hFFFFFFFF : $urandom;
            apb(1'b1, k[0] ? `OFS_CORE_SYNTH : `OFS_VIDEO_SYNTH, d);
            apb(1'b0, k[0] ? `OFS_CORE_SYNTH : `OFS_VIDEO_SYNTH, 32'h0);
            `CHK(rd, {15'h0000, d[16:0]})
            repeat (2) @(posedge pclk);
            if (k[0]) begin
                `CHK({core_osc_test, core_fb_mul, core_post_div}, {d[16:8], d[1:0]})
                `CHK(core_in_div, `FORCED_IN_DIV)
            end else
                `CHK({video_osc_test, video_fb_mul, video_in_div, video_post_div}, d[16:0])
        end
        $display("test synth_fields done");
        apb(1'b1, 12'h04C, 32'hFFFFFFFF);
        `CHK(e, 1'b1)
        apb(1'b0, 12'h04C, 32'h0);
        `CHK({e, rd}, {1'b1, 32'h0})
        apb(1'b1, `OFS_CLOCK_STATUS, 32'hFFFFFFFF);
        `CHK(e, 1'b1)
        $display("test unmapped done");
        for (m = 0; m < 4; m++) begin
            rst(m[1:0]);
            `CHK(fast_bus_capable, m[1])
            `CHK(straps_valid, 1'b1)
            for (k = 0; k < 4; k++) begin
                apb(1'b1, `OFS_BUS_SYNTH, ($urandom & 32'hFFFFFFFC) | k);
                apb(1'b0, `OFS_BUS_SYNTH, 32'h0);
                `CHK(rd, {30'h0, k[1:0]})
                repeat (2) @(posedge pclk);
                `CHK(sel_obs, exp_sel(m[1], m[0], k[1:0]))
                s = exp_sel(m[1], m[0], k[1:0]);
                apb(1'b0, `OFS_CLOCK_STATUS, 32'h0);
                `CHK(rd, {24'h0, 1'b1, s[0], s[1], m[1], m[0], m[1], k[1:0]})
            end
        end
        $display("test strap_modes done");
        rst(2'h2);
        apb(1'b1, `OFS_BUS_SYNTH, 32'h0);
        board_mode <= 2'h0;
        repeat (8) @(posedge pclk);
        `CHK({fast_bus_capable, sel_obs}, {1'b1, exp_sel(1'b1, 1'b0, 2'h0)})
        $display("test strap_hold done");
        conclude;
    end
endmodule // pll_bus_clock_control_test
